/* rtl/dew_cfg.svh */
// offsets, field positions, reset values and timing counts of the data eeprom guard
`ifndef DEW_CFG_SVH
`define DEW_CFG_SVH
`define DEW_OFF_CTRL      4'h0
`define DEW_OFF_KEY       4'h1
`define DEW_OFF_ADDR_LO   4'h2
`define DEW_OFF_ADDR_HI   4'h3
`define DEW_OFF_DATA      4'h4
`define DEW_OFF_STATUS    4'h5
`define DEW_CTRL_RD_BIT   0
`define DEW_CTRL_WR_BIT   1
`define DEW_CTRL_WRITE_ENABLE_LATCH_BIT 2
`define DEW_CTRL_ERR_BIT  3
`define DEW_KEY_FIRST     8'h55
`define DEW_KEY_SECOND    8'haa
`define DEW_RESET_BYTE    8'hff
`define DEW_PWRT_NS       65536
`define DEW_CLK_MHZ       250
`define DEW_PWRT_CYCLES   ((`DEW_PWRT_NS * `DEW_CLK_MHZ) / 1000)
`define DEW_PROG_NS       4000
`define DEW_PROG_CYCLES   ((`DEW_PROG_NS * `DEW_CLK_MHZ) / 1000)
`endif

/* rtl/dew_pkg.sv */
// types shared by the data eeprom guard
package dew_pkg;
   typedef enum logic [1:0]
   {
      DEW_KEY_IDLE = 2'b00,
      DEW_KEY_GOT1 = 2'b01,
      DEW_KEY_ARMD = 2'b10
   } dew_key_t;

   typedef enum logic [1:0]
   {
      DEW_PRG_IDLE = 2'b00,
      DEW_PRG_BUSY = 2'b01
   } dew_prg_t;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } dew_bus_req_t;

   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } dew_ext_req_t;
endpackage

/* rtl/dew_guard.sv */
// data eeprom access and write-protection guard
//
// Behaviour
// - power-up reset clears the write-enable latch; no core write before software sets it
// - every write request is rejected while the power-up timer is running
// - code protect refuses external-path reads and writes
// - the core reads and writes the array whatever code protect says
// - core write starts only with latch set and keys 55h then 0AAh just before; external writes need neither
// - write-start begins programming the addressed byte; bit reads one until done
// - byte-addressable array, byte chosen by low and high address registers
`timescale 1ns/100ps
`include "dew_cfg.svh"

module dew_guard
   import dew_pkg::*;
#(
   parameter int ADDR_W      = 10,
   parameter int PWRT_CYCLES = `DEW_PWRT_CYCLES,
   parameter int PROG_CYCLES = `DEW_PROG_CYCLES
)
(
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // core register port
   input  wire dew_pkg::dew_bus_req_t core_req,
   output logic [7:0]              core_rdata,
   // external programming path
   input  wire dew_pkg::dew_ext_req_t ext_req,
   output logic [7:0]              ext_rdata,
   output logic                    ext_refused,
   // configuration
   input  wire logic               code_protect,
   // status
   output logic                    write_busy,
   output logic                    pwrt_running
);
   import dew_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;
   localparam int PW_W  = $clog2(PWRT_CYCLES + 1);
   localparam int PG_W  = $clog2(PROG_CYCLES + 1);

   // the external path carries a 16-bit address, so a wider array cannot be reached
   generate
      if (ADDR_W < 1 || ADDR_W > 16 || PWRT_CYCLES < 1 || PROG_CYCLES < 1)
      begin : g_bad_params
         $error("dew_guard: unsupported parameter values");
      end
   endgenerate

   logic [7:0]        mem_reg [DEPTH];
   logic [7:0]        addr_lo_reg;
   logic [7:0]        addr_hi_reg;
   logic [7:0]        data_reg;
   logic              write_enable_latch_reg;
   logic              werr_reg;
   dew_key_t          key_reg;
   dew_key_t          key_next;
   dew_prg_t          prg_reg;
   logic [PW_W-1:0]   pwrt_cnt_reg;
   logic [PG_W-1:0]   prog_cnt_reg;
   logic [ADDR_W-1:0] prog_addr_reg;
   logic [7:0]        prog_data_reg;
   logic [7:0]        core_rdata_reg;
   logic [7:0]        ext_rdata_reg;
   logic              ext_refused_reg;

   wire              wr_ctrl   = core_req.wr && core_req.addr == `DEW_OFF_CTRL;
   wire              wr_key    = core_req.wr && core_req.addr == `DEW_OFF_KEY;
   wire              wr_alo    = core_req.wr && core_req.addr == `DEW_OFF_ADDR_LO;
   wire              wr_ahi    = core_req.wr && core_req.addr == `DEW_OFF_ADDR_HI;
   wire              wr_data   = core_req.wr && core_req.addr == `DEW_OFF_DATA;
   wire              busy      = prg_reg == DEW_PRG_BUSY;
   wire              pwrt_on   = pwrt_cnt_reg != '0;
   wire [15:0]       full_addr = {addr_hi_reg, addr_lo_reg};
   wire [ADDR_W-1:0] cur_addr  = full_addr[ADDR_W-1:0];
   wire              set_write_enable_latch  = core_req.wdata[`DEW_CTRL_WRITE_ENABLE_LATCH_BIT];
   wire              wr_req    = wr_ctrl && core_req.wdata[`DEW_CTRL_WR_BIT];
   wire              rd_req    = wr_ctrl && core_req.wdata[`DEW_CTRL_RD_BIT];
   wire              keys_ok   = key_reg == DEW_KEY_ARMD;
   // busy and the timer both veto a start; the refusal is kept in the error flag
   // gated start
   wire              start_ok  = wr_req && write_enable_latch_reg && keys_ok && !busy && !pwrt_on;
   wire              wr_reject = wr_req && !start_ok;
   wire              ext_ok    = !code_protect;
   wire [ADDR_W-1:0] ext_addr  = ext_req.addr[ADDR_W-1:0];
   wire              ext_wr_go = ext_req.wr && ext_ok && !busy && !pwrt_on;
   wire              ext_rd_go = ext_req.rd && ext_ok;
   wire              prog_done = busy && prog_cnt_reg == PG_W'(1);

   wire [7:0] ctrl_view = {4'h0, werr_reg, write_enable_latch_reg, busy, 1'b0};
   wire [7:0] stat_view = {6'h0, pwrt_on, busy};
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      // the key offset falls to the default, so unlock values never read back
      unique case (core_req.addr)
         `DEW_OFF_CTRL:    rd_mux = ctrl_view;
         `DEW_OFF_ADDR_LO: rd_mux = addr_lo_reg;
         `DEW_OFF_ADDR_HI: rd_mux = addr_hi_reg;
         `DEW_OFF_DATA:    rd_mux = data_reg;
         `DEW_OFF_STATUS:  rd_mux = stat_view;
         default:          rd_mux = 8'h00;
      endcase
   end

   // reads between the keys are let through, so a status poll cannot break an unlock
   // key sequencer: any other write between keys disarms
   always_comb
   begin
      key_next = DEW_KEY_IDLE;
      if (wr_key && core_req.wdata == `DEW_KEY_FIRST)
         key_next = DEW_KEY_GOT1;
      else if (wr_key && key_reg == DEW_KEY_GOT1 && core_req.wdata == `DEW_KEY_SECOND)
         key_next = DEW_KEY_ARMD;
      else if (!core_req.wr && key_reg == DEW_KEY_ARMD)
         key_next = DEW_KEY_ARMD;
      else if (!core_req.wr && key_reg == DEW_KEY_GOT1)
         key_next = DEW_KEY_GOT1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         key_reg <= DEW_KEY_IDLE;
      else
         key_reg <= key_next;
   end

   // counts down once per reset; nothing in normal operation restarts it
   // power-up timer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwrt_cnt_reg <= PW_W'(PWRT_CYCLES);
      else if (pwrt_on)
         pwrt_cnt_reg <= pwrt_cnt_reg - PW_W'(1);
   end

   // every control write rewrites the latch, so software keeps its bit set up to the start
   // latch cleared at reset
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         write_enable_latch_reg <= 1'b0;
      else if (wr_ctrl)
         write_enable_latch_reg <= set_write_enable_latch;
   end

   // refused write-start sets the error flag; set wins over a clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         werr_reg <= 1'b0;
      else if (wr_reject)
         werr_reg <= 1'b1;
      else if (wr_ctrl && !core_req.wdata[`DEW_CTRL_ERR_BIT])
         werr_reg <= 1'b0;
   end

   // limitation: address registers stay writable while busy; only the captured copy is used
   // address held by software while busy; not enforced here
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_lo_reg <= 8'h00;
         addr_hi_reg <= 8'h00;
      end
      else
      begin
         if (wr_alo)
            addr_lo_reg <= core_req.wdata;
         if (wr_ahi)
            addr_hi_reg <= core_req.wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         data_reg <= 8'h00;
      else if (rd_req && !busy)
         data_reg <= mem_reg[cur_addr];
      else if (wr_data)
         data_reg <= core_req.wdata;
   end

   // address and data are captured at start: a stray address write cannot redirect a byte
   // programming sequencer, bit reads one while busy
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prg_reg       <= DEW_PRG_IDLE;
         prog_cnt_reg  <= '0;
         prog_addr_reg <= '0;
         prog_data_reg <= 8'h00;
      end
      else if (start_ok)
      begin
         prg_reg       <= DEW_PRG_BUSY;
         prog_cnt_reg  <= PG_W'(PROG_CYCLES);
         prog_addr_reg <= cur_addr;
         prog_data_reg <= data_reg;
      end
      // core wins a same-cycle start; the external request is then dropped silently
      else if (ext_wr_go)
      begin
         prg_reg       <= DEW_PRG_BUSY;
         prog_cnt_reg  <= PG_W'(PROG_CYCLES);
         prog_addr_reg <= ext_addr;
         prog_data_reg <= ext_req.wdata;
      end
      else if (prog_done)
         prg_reg <= DEW_PRG_IDLE;
      else if (busy)
         prog_cnt_reg <= prog_cnt_reg - PG_W'(1);
   end

   // cells reset to the erased value, so a read before any write sees ffh
   // array only changes at the end of an accepted write
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_cell
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               mem_reg[gi] <= `DEW_RESET_BYTE;
            else if (prog_done && prog_addr_reg == ADDR_W'(gi))
               mem_reg[gi] <= prog_data_reg;
         end
      end
   endgenerate

   wire [7:0]        core_rdata_next  = core_req.rd ? rd_mux : 8'h00;
   // a refused or absent read gives zero, so nothing leaks through a protected path
   wire [7:0]        ext_rdata_next   = ext_rd_go ? mem_reg[ext_addr] : 8'h00;
   wire              ext_refused_next = (ext_req.rd || ext_req.wr) && !ext_ok;
   logic             busy_out_reg;
   logic             pwrt_out_reg;
   // busy rises with the accepted start, so a poll just after it already sees one
   wire              busy_out_next    = busy || start_ok || ext_wr_go;

   // register read data stand for one cycle only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         core_rdata_reg <= 8'h00;
      else
         core_rdata_reg <= core_rdata_next;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_rdata_reg <= 8'h00;
      else
         ext_rdata_reg <= ext_rdata_next;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_refused_reg <= 1'b0;
      else
         ext_refused_reg <= ext_refused_next;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         busy_out_reg <= 1'b0;
      else
         busy_out_reg <= busy_out_next;
   end

   // held high from reset: no write slips in before the timer counts
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwrt_out_reg <= 1'b1;
      else
         pwrt_out_reg <= pwrt_on;
   end

   assign core_rdata   = core_rdata_reg;
   assign ext_rdata    = ext_rdata_reg;
   assign ext_refused  = ext_refused_reg;
   assign write_busy   = busy_out_reg;
   assign pwrt_running = pwrt_out_reg;
endmodule

/* tb/dew_guard_props.sv */
// port checks of the data eeprom guard
`timescale 1ns/100ps
`include "dew_cfg.svh"
module dew_guard_props
   import dew_pkg::*;
(
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   // core and external paths
   input wire dew_pkg::dew_bus_req_t core_req,
   input wire logic [7:0]            core_rdata,
   input wire dew_pkg::dew_ext_req_t ext_req,
   input wire logic [7:0]            ext_rdata,
   input wire logic                  ext_refused,
   // config and status
   input wire logic                  code_protect,
   input wire logic                  write_busy,
   input wire logic                  pwrt_running
);
   logic [1:0] key_reg;
   logic [1:0] key_next;
   logic       latch_reg;
   wire        key_wr = core_req.wr && core_req.addr == `DEW_OFF_KEY;
   wire        ctrl_wr = core_req.wr && core_req.addr == `DEW_OFF_CTRL;
   wire        ext_hit = (ext_req.rd || ext_req.wr) && code_protect;
   wire        ext_wr_ok = ext_req.wr && !code_protect;
   // a start that meets latch and keys; timer and busy gating are checked apart
   wire        start_try = ctrl_wr && core_req.wdata[`DEW_CTRL_WR_BIT] && latch_reg
                           && key_reg == 2'd2;
   wire        start_ok = start_try && !pwrt_running && !write_busy;
   // any other write between the keys breaks the sequence
   assign key_next = !core_req.wr ? key_reg : !key_wr ? 2'd0
                   : core_req.wdata == `DEW_KEY_FIRST ? 2'd1
                   : (core_req.wdata == `DEW_KEY_SECOND && key_reg == 2'd1) ? 2'd2 : 2'd0;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_reg   <= 2'd0;
         latch_reg <= 1'b0;
      end
      else
      begin
         key_reg <= key_next;
         if (ctrl_wr)
            latch_reg <= core_req.wdata[`DEW_CTRL_WRITE_ENABLE_LATCH_BIT];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   refuse_ext_a: assert property (ext_hit |=> ext_refused) else $error("ext not refused");
   grant_ext_a: assert property (!ext_hit |=> !ext_refused) else $error("ext refused");
   refused_data_a: assert property (ext_refused |-> ext_rdata == 8'h00)
      else $error("refused read leaked data");
   idle_rdata_a: assert property (!core_req.rd |=> core_rdata == 8'h00)
      else $error("read data outside read slot");
   pwrt_block_a: assert property (pwrt_running |-> !write_busy)
      else $error("write during power-up timer");
   pwrt_once_a: assert property (!pwrt_running |=> !pwrt_running)
      else $error("power-up timer restarted");
   start_busy_a: assert property (start_ok |=> write_busy ##1 write_busy)
      else $error("unlocked start did not program");
   busy_cause_a: assert property ($rose(write_busy) |-> $past(start_try || ext_wr_ok))
      else $error("programming without unlock");
endmodule
bind dew_guard dew_guard_props i_props (.core_clk(core_clk), .rst_n(rst_n),
   .core_req(core_req), .core_rdata(core_rdata), .ext_req(ext_req), .ext_rdata(ext_rdata),
   .ext_refused(ext_refused), .code_protect(code_protect), .write_busy(write_busy),
   .pwrt_running(pwrt_running));

/* tb/dew_ext_model.sv */
// external programmer model driving the guard's external path
`timescale 1ns/100ps
module dew_ext_model
   import dew_pkg::*;
(
   input wire logic       core_clk,
   output dew_pkg::dew_ext_req_t ext_req
);
   initial ext_req = '0;
   // released lines flip so a stale value never looks valid
   task automatic pulse(input logic w, input logic [15:0] a, input logic [7:0] d);
      ext_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      ext_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

/* tb/tb_data_eeprom_write_guard.sv */
// self-checking bench of the data eeprom guard
`timescale 1ns/100ps
`include "dew_cfg.svh"
module tb_data_eeprom_write_guard;
   import dew_pkg::*;
   logic         core_clk;
   logic         rst_n;
   dew_bus_req_t core_req;
   dew_ext_req_t ext_req;
   logic [7:0]   core_rdata;
   logic [7:0]   ext_rdata;
   logic         ext_refused;
   logic         code_protect;
   logic         write_busy;
   logic         pwrt_running;
   logic [7:0]   mem [0:1023];
   logic [31:0]  rnd;
   logic [9:0]   a;
   logic [7:0]   q;
   int           fail_count = 0;
   int           check_count = 0;
   int           cyc = 0;
   dew_guard #(.ADDR_W(10), .PWRT_CYCLES(40), .PROG_CYCLES(4)) i_dut (.core_clk(core_clk),
      .rst_n(rst_n), .core_req(core_req), .core_rdata(core_rdata), .ext_req(ext_req),
      .ext_rdata(ext_rdata), .ext_refused(ext_refused), .code_protect(code_protect),
      .write_busy(write_busy), .pwrt_running(pwrt_running));
   dew_ext_model i_ext (.core_clk(core_clk), .ext_req(ext_req));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (e !== g)
      begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] d);
      core_req <= '{wr: w, rd: !w, addr: ad, wdata: d};
      @(posedge core_clk);
      core_req <= '{wr: 1'b0, rd: 1'b0, addr: ~ad, wdata: ~d};
      #1 q = core_rdata;
      @(posedge core_clk);
   endtask
   task automatic poll();
      bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      for (int i = 0; i < 50 && q[1] !== 1'b0; i++)
         bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      chk("write done", 8'h00, q & 8'h02);
   endtask
   task automatic unlock(input logic [7:0] c);
      bus(1'b1, `DEW_OFF_CTRL, c & 8'h04);
      bus(1'b1, `DEW_OFF_KEY, `DEW_KEY_FIRST);
      bus(1'b1, `DEW_OFF_KEY, `DEW_KEY_SECOND);
      bus(1'b1, `DEW_OFF_CTRL, c);
   endtask
   task automatic setup(input logic [9:0] ad, input logic [7:0] d);
      bus(1'b1, `DEW_OFF_ADDR_LO, ad[7:0]);
      bus(1'b1, `DEW_OFF_ADDR_HI, {6'h00, ad[9:8]});
      bus(1'b1, `DEW_OFF_DATA, d);
   endtask
   task automatic eread(input logic [9:0] ad);
      setup(ad, 8'h00);
      bus(1'b1, `DEW_OFF_CTRL, 8'h01);
      bus(1'b0, `DEW_OFF_DATA, 8'h00);
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      core_req = '0;
      code_protect = 1'b0;
      rst_n = 1'b0;
      rnd = 32'hdab0b481;
      for (int i = 0; i < 1024; i++)
         mem[i] = `DEW_RESET_BYTE;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1 chk("timer", 8'h01, {7'h00, pwrt_running});
      setup(10'h005, 8'h3c);
      unlock(8'h06);
      bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      chk("early start", 8'h08, q & 8'h0a);
      for (int i = 0; i < 100 && pwrt_running !== 1'b0; i++)
         @(posedge core_clk);
      chk("timer end", 8'h00, {7'h00, pwrt_running});
      bus(1'b1, `DEW_OFF_CTRL, 8'h00);
      unlock(8'h02);
      bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      chk("no latch", 8'h08, q & 8'h0a);
      bus(1'b1, `DEW_OFF_CTRL, 8'h04);
      bus(1'b1, `DEW_OFF_KEY, `DEW_KEY_SECOND);
      bus(1'b1, `DEW_OFF_KEY, `DEW_KEY_FIRST);
      bus(1'b1, `DEW_OFF_CTRL, 8'h06);
      bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      chk("bad keys", 8'h08, q & 8'h0a);
      eread(10'h005);
      chk("untouched", 8'hff, q);
      $display("test guards done");
      for (int n = 0; n < 8; n++)
      begin
         rnd = lfsr(rnd);
         a = (n == 0) ? 10'h000 : (n == 1) ? 10'h3ff : rnd[9:0];
         setup(a, rnd[17:10]);
         unlock(8'h06);
         bus(1'b0, `DEW_OFF_CTRL, 8'h00);
         chk("busy", 8'h02, q & 8'h02);
         poll();
         mem[a] = rnd[17:10];
         eread(rnd[29:20]);
         chk("other byte", mem[rnd[29:20]], q);
         eread(a);
         chk("read back", mem[a], q);
      end
      $display("test writes done");
      code_protect <= 1'b1;
      i_ext.pulse(1'b1, {6'h00, a}, 8'h5a);
      #1 chk("ext wr refused", 8'h01, {7'h00, ext_refused});
      @(posedge core_clk);
      i_ext.pulse(1'b0, {6'h00, a}, 8'h00);
      #1 chk("ext rd data", 8'h00, ext_rdata);
      chk("ext rd refused", 8'h01, {7'h00, ext_refused});
      @(posedge core_clk);
      eread(a);
      chk("ext wr blocked", mem[a], q);
      setup(a, 8'hc3);
      unlock(8'h06);
      poll();
      mem[a] = 8'hc3;
      eread(a);
      chk("core under protect", mem[a], q);
      code_protect <= 1'b0;
      i_ext.pulse(1'b0, {6'h00, a}, 8'h00);
      #1 chk("ext read", mem[a], ext_rdata);
      chk("ext granted", 8'h00, {7'h00, ext_refused});
      @(posedge core_clk);
      i_ext.pulse(1'b1, {6'h00, a}, 8'h96);
      @(posedge core_clk);
      poll();
      eread(a);
      chk("ext write", 8'h96, q);
      $display("test protect done");
      bus(1'b1, `DEW_OFF_CTRL, 8'h04);
      bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      chk("latch set", 8'h04, q & 8'h04);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1 chk("timer again", 8'h01, {7'h00, pwrt_running});
      bus(1'b0, `DEW_OFF_CTRL, 8'h00);
      chk("latch cleared", 8'h00, q & 8'h04);
      $display("test reset done");
      close_out();
   end
endmodule
